// File: network_association_filter.sv
`timescale 1ns/100ps
// Functional notes
// - high pulse of 20 ms, release starts learning
// - learning drives association pin high as output
// - store first sender id, drop its payload
// - blink pin three times after new id
// - exit on learn or 10 s; low, then input
// - at most 60 ids, no single delete
// - 10 s hold then release erases list
// - fast alternating pin pattern after erase
// - network modes forward only listed senders
// - empty list in network mode forwards nothing
// - filtering applies in modes 3, 5, 7
// - active-low reset pin holds device idle
// - straps resampled at each reset release
// - straps ignored between resets
// - 32-bit serial id stored and compared
module network_association_filter
  import assoc_pkg::*;
#(
  parameter logic [31:0] LEARN_MIN = LEARN_MIN_CYC, // shortest learn pulse
  parameter logic [31:0] ERASE_HOLD = ERASE_HOLD_CYC, // erase hold length
  parameter logic [31:0] LEARN_TIMEOUT = LEARN_TIMEOUT_CYC, // learning window
  parameter logic [31:0] CONFIRM_HALF = CONFIRM_HALF_CYC, // blink half period
  parameter logic [31:0] ERASE_SHOW = ERASE_SHOW_CYC, // empty pattern length
  parameter logic [31:0] ERASE_HALF = ERASE_HALF_CYC // empty pattern half period
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic [MODE_W-1:0] mode_strap,
  input wire logic learn_pin_i,
  output logic learn_pin_o,
  output logic learn_pin_oe,
  input wire logic rx_valid,
  input wire logic [ID_W-1:0] rx_sender_id,
  input wire logic [PAYLOAD_W-1:0] rx_payload,
  output logic fwd_valid,
  output logic [PAYLOAD_W-1:0] fwd_payload,
  output logic [MODE_W-1:0] op_mode,
  output logic learning,
  output logic list_empty
);
  // pin synchronisers, first stage read only by second
  logic [1:0] learn_sync_ff;
  logic [1:0] rstpin_sync_ff;
  logic [MODE_W-1:0] strap_meta_ff;
  logic [MODE_W-1:0] strap_sync_ff;
  logic learn_s; // synchronised association pin
  logic rstpin_s; // synchronised reset pin, high = run

  // controller state and counters
  assoc_state_t state_ff;
  assoc_state_t nxt_state;
  logic [31:0] hold_ff; // cycles the pin has been high
  logic [31:0] timer_ff; // per-state elapsed cycles
  logic [31:0] half_ff; // blink half-period counter
  logic [2:0] phase_ff; // blink halves done
  logic blink_ff; // erase pattern level
  logic [MODE_W-1:0] mode_ff; // latched operating mode
  logic strap_take; // reset release sample point
  logic pin_fall; // end of a user hold
  logic half_done; // blink half period elapsed

  // registered outputs
  logic learn_o_ff;
  logic learn_oe_ff;
  logic fwd_valid_ff;
  logic [PAYLOAD_W-1:0] fwd_payload_ff;
  logic learning_ff;
  logic list_empty_ff;

  id_list_if #(.ID_W(ID_W), .MAX_IDS(MAX_IDS)) lst ();

  id_store #(.DEPTH(MAX_IDS)) u_store (
    .clk_sys(clk_sys),
    .rst(rst),
    .lst(lst)
  );

  // two-stage capture of asynchronous pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      learn_sync_ff <= 2'h0;
      rstpin_sync_ff <= 2'h0;
      strap_meta_ff <= MODE_RST;
      strap_sync_ff <= MODE_RST;
    end else begin
      learn_sync_ff <= {learn_sync_ff[0], learn_pin_i};
      rstpin_sync_ff <= {rstpin_sync_ff[0], reset_pin_n};
      strap_meta_ff <= mode_strap;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  assign learn_s = learn_sync_ff[1];
  assign rstpin_s = rstpin_sync_ff[1];
  // our own drive would read back high, so only idle sees the user
  assign pin_fall = (state_ff == st_idle) && !learn_s && (hold_ff != 32'h0);
  assign strap_take = (state_ff == st_reset_hold) && rstpin_s;
  assign half_done = (state_ff == st_confirm) ? (half_ff >= CONFIRM_HALF - 32'h1)
                                              : (half_ff >= ERASE_HALF - 32'h1);

  // list port: packets are always looked up by sender
  assign lst.lookup_id = rx_sender_id;
  // first packet in window is learned
  assign lst.wr_en = (state_ff == st_learn) && rx_valid;
  assign lst.clr = pin_fall && (hold_ff >= ERASE_HOLD);

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_reset_hold: begin
        // run once reset pin is high
        if (rstpin_s) begin
          nxt_state = st_idle;
        end
      end
      st_idle: begin
        if (pin_fall) begin
          if (hold_ff >= ERASE_HOLD) begin
            nxt_state = st_erase_show;
          end else if (hold_ff >= LEARN_MIN) begin
            nxt_state = st_learn;
          end
        end
      end
      st_learn: begin
        if (rx_valid) begin
          // nothing new stored, leave at once
          nxt_state = (lst.hit || lst.full) ? st_exit : st_confirm;
        end else if (timer_ff >= LEARN_TIMEOUT - 32'h1) begin
          nxt_state = st_exit;
        end
      end
      st_confirm: begin
        if (half_done && (phase_ff == 3'((CONFIRM_PULSES << 1) - 3'h1))) begin
          nxt_state = st_exit;
        end
      end
      st_exit: begin
        nxt_state = st_idle;
      end
      st_erase_show: begin
        if (timer_ff >= ERASE_SHOW - 32'h1) begin
          nxt_state = st_idle;
        end
      end
      default: begin
        nxt_state = st_reset_hold;
      end
    endcase
  end

  // state register; a low reset pin overrides the next state, rst overrides both
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= st_reset_hold;
    end else if (!rstpin_s) begin
      // held in reset while pin low
      state_ff <= st_reset_hold;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ff <= MODE_RST;
    end else if (strap_take) begin
      mode_ff <= strap_sync_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_ff <= 32'h0;
    end else if (state_ff != st_idle || !learn_s) begin
      hold_ff <= 32'h0;
    end else if (hold_ff != 32'hFFFF_FFFF) begin
      hold_ff <= hold_ff + 32'h1;
    end
  end

  // elapsed time in the current state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_ff <= 32'h0;
    end else if (nxt_state != state_ff || !rstpin_s) begin
      timer_ff <= 32'h0;
    end else begin
      timer_ff <= timer_ff + 32'h1;
    end
  end

  // blink timing shared by confirm and erase patterns
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      half_ff <= 32'h0;
      phase_ff <= 3'h0;
      blink_ff <= 1'b0;
    end else if (state_ff != st_confirm && state_ff != st_erase_show) begin
      half_ff <= 32'h0;
      phase_ff <= 3'h0;
      blink_ff <= 1'b1;
    end else if (half_done) begin
      half_ff <= 32'h0;
      phase_ff <= phase_ff + 3'h1;
      blink_ff <= !blink_ff;
    end else begin
      half_ff <= half_ff + 32'h1;
    end
  end

  // association pin drive
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      learn_o_ff <= 1'b0;
      learn_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        st_learn: begin
          learn_oe_ff <= 1'b1;
          learn_o_ff <= 1'b1;
        end
        st_confirm: begin
          // even halves on, odd halves off
          learn_oe_ff <= 1'b1;
          learn_o_ff <= !phase_ff[0];
        end
        st_exit: begin
          learn_oe_ff <= 1'b1;
          learn_o_ff <= 1'b0;
        end
        st_erase_show: begin
          learn_oe_ff <= 1'b1;
          learn_o_ff <= blink_ff;
        end
        default: begin
          learn_oe_ff <= 1'b0;
          learn_o_ff <= 1'b0;
        end
      endcase
    end
  end

  // receive filter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fwd_valid_ff <= 1'b0;
      fwd_payload_ff <= '0;
    end else begin
      fwd_valid_ff <= rx_valid && (state_ff == st_idle) && rstpin_s &&
                      (!is_net_mode(mode_ff) || (lst.count != '0 && lst.hit));
      if (rx_valid) begin
        fwd_payload_ff <= rx_payload;
      end
    end
  end

  // status flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      learning_ff <= 1'b0;
      list_empty_ff <= 1'b1;
    end else begin
      learning_ff <= (state_ff == st_learn);
      list_empty_ff <= (lst.count == '0);
    end
  end

  assign learn_pin_o = learn_o_ff;
  assign learn_pin_oe = learn_oe_ff;
  assign fwd_valid = fwd_valid_ff;
  assign fwd_payload = fwd_payload_ff;
  assign op_mode = mode_ff;
  assign learning = learning_ff;
  assign list_empty = list_empty_ff;

  // exit sequence: low drive, then released
  sequence s_exit_low;
    learn_oe_ff && !learn_o_ff;
  endsequence
  sequence s_released;
    !learn_oe_ff;
  endsequence

  chk_learn_drive: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == st_learn) |=> (learn_oe_ff && learn_o_ff))
    else $error("pin not driven high while learning");
  chk_exit_order: assert property (@(posedge clk_sys) disable iff (rst || !rstpin_s)
    (state_ff == st_exit && rstpin_s) |=> s_exit_low ##1 s_released)
    else $error("exit did not drive low then release");
  chk_filter_pass: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_valid && state_ff == st_idle && is_net_mode(mode_ff) && !lst.hit) |=> !fwd_valid)
    else $error("unlisted sender forwarded");
  chk_empty_mute: assert property (@(posedge clk_sys) disable iff (rst)
    (is_net_mode(mode_ff) && lst.count == '0) |=> !fwd_valid)
    else $error("data forwarded with empty list");
  chk_learn_discard: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == st_learn && rx_valid) |=> (!fwd_valid ##1 !learning))
    else $error("learning packet forwarded or window kept");
  chk_strap_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !strap_take |=> (mode_ff == $past(mode_ff)))
    else $error("mode changed outside reset release");
  chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (!rstpin_s ##1 !rstpin_s) |=> (!learn_pin_oe && !fwd_valid))
    else $error("activity while reset pin low");
  chk_learn_store: assert property (@(posedge clk_sys) disable iff (rst)
    (lst.wr_en && !lst.hit && !lst.full) |=> (lst.count == $past(lst.count) + 1'b1))
    else $error("new id not stored");
  chk_erase_clear: assert property (@(posedge clk_sys) disable iff (rst)
    lst.clr |=> (lst.count == '0) ##1 list_empty)
    else $error("list not cleared after long hold");
endmodule

// File: assoc_pkg.sv
package assoc_pkg;
  // identifier and list geometry
  localparam int ID_W = 32;
  localparam int MAX_IDS = 60;
  localparam int PAYLOAD_W = 8;
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_RST = 3'h0;
  // clock rate, cycles per millisecond at 50 MHz
  localparam longint CLK_PER_MS = 50000;
  // user pulse and hold thresholds, in milliseconds
  localparam longint LEARN_MIN_MS = 20;
  localparam longint ERASE_HOLD_MS = 10000;
  // learning window length
  localparam longint LEARN_TIMEOUT_MS = 10000;
  // success blink: half period and number of pulses
  localparam longint CONFIRM_HALF_MS = 100;
  localparam logic [2:0] CONFIRM_PULSES = 3'h3;
  // list-empty pattern: total length and half period
  localparam longint ERASE_SHOW_MS = 2000;
  localparam longint ERASE_HALF_MS = 50;
  // derived cycle counts, exact multiples so no rounding is lost
  localparam logic [31:0] LEARN_MIN_CYC = 32'(LEARN_MIN_MS * CLK_PER_MS);
  localparam logic [31:0] ERASE_HOLD_CYC = 32'(ERASE_HOLD_MS * CLK_PER_MS);
  localparam logic [31:0] LEARN_TIMEOUT_CYC = 32'(LEARN_TIMEOUT_MS * CLK_PER_MS);
  localparam logic [31:0] CONFIRM_HALF_CYC = 32'(CONFIRM_HALF_MS * CLK_PER_MS);
  localparam logic [31:0] ERASE_SHOW_CYC = 32'(ERASE_SHOW_MS * CLK_PER_MS);
  localparam logic [31:0] ERASE_HALF_CYC = 32'(ERASE_HALF_MS * CLK_PER_MS);

  // controller states
  typedef enum logic [2:0] {
    st_reset_hold,
    st_idle,
    st_learn,
    st_confirm,
    st_exit,
    st_erase_show
  } assoc_state_t;

  // network modes are the odd receive modes above 1: 3, 5 and 7
  function automatic logic is_net_mode(input logic [2:0] mode);
    is_net_mode = (mode == 3'h3) || (mode == 3'h5) || (mode == 3'h7);
  endfunction
endpackage

// File: id_list_if.sv
`timescale 1ns/100ps
// link between the controller and the identifier store
interface id_list_if #(
  parameter int ID_W = 32,
  parameter int MAX_IDS = 60
);
  localparam int CNT_W = $clog2(MAX_IDS + 1);
  logic [ID_W-1:0] lookup_id; // sender under test
  logic hit; // sender already stored
  logic full; // no free entry
  logic [CNT_W-1:0] count; // entries in use
  logic wr_en; // store lookup_id
  logic clr; // wipe whole list
  modport store (input lookup_id, input wr_en, input clr, output hit, output full, output count);
  modport ctrl (output lookup_id, output wr_en, output clr, input hit, input full, input count);
endinterface

// File: id_store.sv
`timescale 1ns/100ps
// learned identifier list with parallel lookup
module id_store
  import assoc_pkg::*;
#(
  parameter int DEPTH = MAX_IDS
) (
  input wire logic clk_sys,
  input wire logic rst,
  id_list_if.store lst
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [ID_W-1:0] mem [DEPTH]; // stored identifiers, no reset needed
  logic [CW-1:0] count_ff; // entries in use
  logic [DEPTH-1:0] match; // per-entry compare

  // compare every live entry at once; entries above count are stale
  for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
    assign match[i] = (CW'(i) < count_ff) && (mem[i] == lst.lookup_id);
  end

  assign lst.hit = |match;
  assign lst.full = (count_ff == CW'(DEPTH));
  assign lst.count = count_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_ff <= '0;
    end else if (lst.clr) begin
      count_ff <= '0;
    end else if (lst.wr_en && !lst.hit && !lst.full) begin
      count_ff <= count_ff + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (lst.wr_en && !lst.hit && !lst.full && !lst.clr) begin
      mem[count_ff] <= lst.lookup_id;
    end
  end

  chk_list_bound: assert property (@(posedge clk_sys) disable iff (rst)
    count_ff <= CW'(DEPTH)) else $error("id list count above depth");

  chk_dup_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (lst.wr_en && lst.hit && !lst.clr) |=> $stable(count_ff))
    else $error("duplicate id changed the list");
endmodule

// File: assoc_user_model.sv
`timescale 1ns/100ps
// user circuitry around the association pin and the device reset pin
module assoc_user_model (
  input wire logic clk_sys,
  input wire logic learn_pin_o,
  input wire logic learn_pin_oe,
  output logic learn_pin_i,
  output logic reset_pin_n
);
  logic user_drive; // user pushes the pin high through a series resistor

  // idle board: pin pulled down, reset pin pulled up
  initial begin
    user_drive = 1'b0;
    reset_pin_n = 1'b1;
  end

  // pin level: device drive beats the series resistor, pull-down when undriven
  always_comb begin
    learn_pin_i = learn_pin_oe ? learn_pin_o : user_drive;
  end

  task automatic press(input int hold_cyc);
    @(posedge clk_sys);
    user_drive <= 1'b1;
    repeat (hold_cyc) @(posedge clk_sys);
    user_drive <= 1'b0;
  endtask

  task automatic reset_pulse(input int low_cyc);
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    repeat (low_cyc) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
  endtask
endmodule

// File: network_association_filter_tb.sv
`timescale 1ns/100ps
module network_association_filter_tb
  import assoc_pkg::*;
;
  // short counts so the run stays small
  localparam int P_MIN = 20;
  localparam int P_ERASE = 60;
  localparam int P_TO = 100;
  localparam logic [31:0] ID_BASE = 32'hA5000000; // arbitrary sender ids

  // one table row: mode, sender, payload, forwarded or not
  typedef struct packed {
    logic [2:0] mode;
    logic [31:0] id;
    logic [7:0] pay;
    logic fwd;
  } row_t;

  logic clk_sys = 1'b0; // 50 MHz
  logic rst;
  logic reset_pin_n;
  logic [MODE_W-1:0] mode_strap;
  logic learn_pin_i;
  logic learn_pin_o;
  logic learn_pin_oe;
  logic rx_valid;
  logic [ID_W-1:0] rx_sender_id;
  logic [PAYLOAD_W-1:0] rx_payload;
  logic fwd_valid;
  logic [PAYLOAD_W-1:0] fwd_payload;
  logic [MODE_W-1:0] op_mode;
  logic learning;
  logic list_empty;
  int err_total = 0; // mismatches
  int checks_done = 0; // comparisons
  row_t rows [10]; // ordinary receive cases
  int falls; // high-to-low steps of the pin drive
  int cyc; // cycles the device drove the pin

  always #10 clk_sys = ~clk_sys;

  network_association_filter #(
    .LEARN_MIN(32'(P_MIN)), .ERASE_HOLD(32'(P_ERASE)), .LEARN_TIMEOUT(32'(P_TO)),
    .CONFIRM_HALF(32'h4), .ERASE_SHOW(32'h28), .ERASE_HALF(32'h4)
  ) dut (
    .clk_sys(clk_sys), .rst(rst), .reset_pin_n(reset_pin_n), .mode_strap(mode_strap),
    .learn_pin_i(learn_pin_i), .learn_pin_o(learn_pin_o), .learn_pin_oe(learn_pin_oe),
    .rx_valid(rx_valid), .rx_sender_id(rx_sender_id), .rx_payload(rx_payload),
    .fwd_valid(fwd_valid), .fwd_payload(fwd_payload), .op_mode(op_mode),
    .learning(learning), .list_empty(list_empty)
  );

  assoc_user_model u_user (
    .clk_sys(clk_sys), .learn_pin_o(learn_pin_o), .learn_pin_oe(learn_pin_oe),
    .learn_pin_i(learn_pin_i), .reset_pin_n(reset_pin_n)
  );

  // compare and count, four-state exact
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // verdict, the single end of the run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one packet, then watch the one-cycle forward pulse
  task automatic send(input logic [31:0] id, input logic [7:0] pay, input logic exp,
                      input string nm);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_sender_id <= id;
    rx_payload <= pay;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    @(negedge clk_sys);
    check(nm, fwd_valid, exp);
    if (exp) begin
      check(nm, fwd_payload, pay);
    end
    @(negedge clk_sys);
    check(nm, fwd_valid, 1'b0);
  endtask

  // follow the pin while the device drives it; counts falls and length
  // first_o is the level last seen, so a fall just before the call still counts
  task automatic watch_pin(input logic chk_low, input logic first_o);
    logic prev_o;
    prev_o = first_o;
    falls = 0;
    cyc = 0;
    while (learn_pin_oe === 1'b1 && cyc < 400) begin
      if (prev_o === 1'b1 && learn_pin_o === 1'b0) falls++;
      prev_o = learn_pin_o;
      @(negedge clk_sys);
      cyc++;
    end
    check("pin released", learn_pin_oe, 1'b0);
    if (chk_low) begin
      check("last drive low", prev_o, 1'b0);
    end
  endtask

  // medium hold opens learning; optionally offer a sender
  task automatic learn(input logic [31:0] id, input logic pkt, input int exp_falls);
    int n;
    u_user.press(P_MIN + 5);
    n = 0;
    while (learn_pin_oe !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check("learn drive high", learn_pin_o, 1'b1);
    check("learning flag", learning, 1'b1);
    if (pkt) begin
      send(id, 8'h5A, 1'b0, "learn payload");
    end
    // pin was seen high when the window opened
    watch_pin(1'b1, 1'b1);
    check("confirm falls", falls, exp_falls);
  endtask

  // change straps, prove they wait for a reset pin pulse
  task automatic set_mode(input logic [2:0] m);
    logic [2:0] old_m;
    old_m = op_mode;
    @(posedge clk_sys);
    mode_strap <= m;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("mode held", op_mode, old_m);
    u_user.reset_pulse(4);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("mode resampled", op_mode, m);
  endtask

  // hang guard, well beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    summarize();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    mode_strap = 3'h3;
    rx_valid = 1'b0;
    rx_sender_id = 32'h0;
    rx_payload = 8'h0;
    rows[0] = '{3'h3, ID_BASE, 8'h21, 1'b1};
    rows[1] = '{3'h3, ID_BASE + 32'h3B, 8'h22, 1'b1};
    rows[2] = '{3'h3, ID_BASE ^ 32'h80000000, 8'h23, 1'b0};
    rows[3] = '{3'h3, ID_BASE + 32'h3C, 8'h24, 1'b0};
    rows[4] = '{3'h5, ID_BASE + 32'h1, 8'h25, 1'b1};
    rows[5] = '{3'h5, 32'h00000001, 8'h26, 1'b0};
    rows[6] = '{3'h7, ID_BASE + 32'h2, 8'h27, 1'b1};
    rows[7] = '{3'h7, ID_BASE + 32'h3C, 8'h28, 1'b0};
    rows[8] = '{3'h1, ID_BASE + 32'h3C, 8'h29, 1'b1};
    rows[9] = '{3'h0, 32'h12345678, 8'h2A, 1'b1};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("mode at start", op_mode, 3'h3);
    check("empty at start", list_empty, 1'b1);
    send(ID_BASE, 8'h11, 1'b0, "empty list");
    // a too-short pulse must not open learning
    u_user.press(P_MIN - 5);
    repeat (10) @(negedge clk_sys);
    check("short pulse", learn_pin_oe, 1'b0);
    for (int i = 0; i < MAX_IDS; i++) begin
      learn(ID_BASE + 32'(i), 1'b1, 3);
    end
    check("list filled", list_empty, 1'b0);
    learn(ID_BASE + 32'h3C, 1'b1, 1);
    learn(ID_BASE + 32'h3, 1'b1, 1);
    // nobody transmits: window times out
    learn(32'h0, 1'b0, 1);
    check("window length", 32'(cyc >= P_TO - 3 && cyc <= P_TO + 4), 32'h1);
    // table of senders across modes
    for (int i = 0; i < 10; i++) begin
      if (rows[i].mode !== op_mode) set_mode(rows[i].mode);
      send(rows[i].id, rows[i].pay, rows[i].fwd, "table row");
    end
    // packet during reset pin low is lost, list survives the pulse
    fork
      u_user.reset_pulse(8);
      begin
        repeat (4) @(posedge clk_sys);
        send(32'h12345678, 8'h33, 1'b0, "held in reset");
      end
    join
    set_mode(3'h3);
    send(ID_BASE + 32'h5, 8'h34, 1'b1, "list after reset");
    // long hold erases, then the empty pattern plays
    u_user.press(P_ERASE + 5);
    repeat (6) @(negedge clk_sys);
    check("list erased", list_empty, 1'b1);
    check("pattern drive", learn_pin_oe, 1'b1);
    watch_pin(1'b0, learn_pin_o);
    check("pattern toggles", 32'(falls >= 4), 32'h1);
    send(ID_BASE, 8'h35, 1'b0, "after erase");
    summarize();
  end
endmodule
